// File: cws_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CWS_MAP_SVH
`define CWS_MAP_SVH
`define CWS_OFF_CTRL      8'h00
`define CWS_OFF_IDLE      8'h04
`define CWS_OFF_ACQ       8'h08
`define CWS_OFF_NZ        8'h0c
`define CWS_OFF_DTIME     8'h10
`define CWS_OFF_RATIO     8'h14
`define CWS_OFF_CODE      8'h18
`define CWS_OFF_TARE      8'h1c
`define CWS_OFF_TARGET    8'h20
`define CWS_OFF_STATUS    8'h24
`define CWS_OFF_RESULT    8'h28
`define CWS_OFF_SSEL      8'h30
`define CWS_OFF_SCOUNT    8'h34
`define CWS_OFF_SSUM_LO   8'h38
`define CWS_OFF_SSUM_HI   8'h3c
`define CWS_OFF_SMEAN     8'h40
`define CWS_OFF_SMAX      8'h44
`define CWS_OFF_SMIN      8'h48
`define CWS_OFF_SRANGE    8'h4c
`define CWS_OFF_SLAST     8'h50
`define CWS_OFF_SPDEV     8'h54
`define CWS_OFF_SSDEV     8'h58
`define CWS_OFF_RSEL      8'h5c
`define CWS_OFF_RDATA     8'h60
`define CWS_OFF_RINFO     8'h64
`define CWS_CTL_TRIM      0
`define CWS_CTL_WIN       1
`define CWS_CTL_AUTO      3
`define CWS_CTL_JSRC      4
`define CWS_CTL_CAP       6
`define CWS_CTL_RCLR      8
`define CWS_CTL_CCLR      9
`define CWS_STS_BUSY      0
`define CWS_STS_SBUSY     1
`define CWS_STS_PVLD      2
`define CWS_STS_SVLD      3
`define CWS_STS_DONE      4
`define CWS_STS_TAKE      5
`define CWS_RINFO_JDG     8
`define CWS_RINFO_VLD     31
`define CWS_RATIO_RST     14'h03e8
`define CWS_RATIO_UNIT    32'h0000_03e8
`define CWS_ACQ_RST       10'h001
`define CWS_WMAX          24'h01869f
`define CWS_CLK_PERIOD_NS 100
`define CWS_DONE_UNIT_NS  100000000
`endif

// File: cws_pkg.sv
// Types and widths of the checkweigh sequence and statistics block
package cws_pkg;
   localparam int W       = 24;
   localparam int DN      = 80;
   localparam int SQ_BITS = 64;
   localparam int NCODES  = 100;
   localparam int SDEPTH  = 1024;

   typedef enum logic [4:0] {
      ST_IDLE, ST_WAIT, ST_ACQ, ST_WIN, ST_MM, ST_BND, ST_SCAN, ST_AVG, ST_SCALE,
      ST_FIN, ST_SMEAN, ST_SQ, ST_SP, ST_SPD, ST_SS, ST_SSD, ST_DIV, ST_SQRT
   } cws_state_t;

   typedef struct packed {
      logic              ctl_trim;
      logic [1:0]        ctl_win;
      logic              ctl_auto;
      logic [1:0]        ctl_jsrc;
      logic [1:0]        ctl_cap;
      logic [9:0]        idle_cnt;
      logic [9:0]        acq_cnt;
      logic [W-1:0]      nz_thr;
      logic [6:0]        done_time;
      logic [13:0]       ratio;
      logic [6:0]        code;
      logic [W-1:0]      tare;
      logic [W-1:0]      target;
      logic [W-1:0]      result;
      logic [6:0]        stat_sel;
      logic [2:0]        rec_sel;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      cws_state_t        st;
      cws_state_t        ret;
      logic [9:0]        tick;
      logic [9:0]        n;
      logic [9:0]        idx;
      logic [9:0]        first;
      logic [9:0]        last;
      logic [9:0]        len;
      logic [W-1:0]      mn;
      logic [W-1:0]      mx;
      logic [W-1:0]      emin;
      logic [W-1:0]      emax;
      logic [33:0]       all_sum;
      logic [33:0]       sel_sum;
      logic [9:0]        sel_n;
      logic [DN-1:0]     dnum;
      logic [31:0]       dden;
      logic [DN-1:0]     dq;
      logic [33:0]       drem;
      logic [6:0]        cnt;
      logic [31:0]       st_mean;
      logic [63:0]       st_num;
      logic [31:0]       st_p;
      logic [31:0]       st_s;
      logic              pval;
      logic              sval;
      logic              st_pend;
      logic              done;
      logic              over;
      logic              go;
      logic              under;
      logic              taking;
      logic [31:0]       done_cnt;
      logic [2:0]        rec_wp;
      logic [7:0]        rec_vld;
      logic [NCODES-1:0] code_vld;
   } cws_regs_t;
endpackage

// File: cws_top.sv
// Checkweigh sequence, averaging and per-code statistics with APB registers
`timescale 1ns/1ps
`include "cws_map.svh"
module cws_top import cws_pkg::*; #(
   parameter int DONE_UNIT_CYC = `CWS_DONE_UNIT_NS / `CWS_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // APB slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // Weight front end
   input  wire logic         sample_valid,
   input  wire logic [W-1:0] sample_weight,
   // Sequence control
   input  wire logic         meas_start,
   input  wire logic         manual_accum,
   input  wire logic         capture_req,
   input  wire logic         judge_over,
   input  wire logic         judge_go,
   input  wire logic         judge_under,
   // Status outputs
   output logic              complete,
   output logic              res_over,
   output logic              res_go,
   output logic              res_under,
   output logic              taking_in
);
   cws_regs_t r;
   cws_regs_t n;

   logic [W-1:0]  smp_mem [SDEPTH];
   logic [15:0]   cnt_mem [NCODES];
   logic [39:0]   sum_mem [NCODES];
   logic [63:0]   sq_mem  [NCODES];
   logic [W-1:0]  max_mem [NCODES];
   logic [W-1:0]  min_mem [NCODES];
   logic [W-1:0]  last_mem [NCODES];
   logic [33:0]   rec_mem [8];

   logic          smp_we;
   logic          acc_we;
   logic          clr_code;
   logic [1:0]    acc_jdg;
   logic [W-1:0]  acc_w;
   logic          av;
   logic [15:0]   c_o;
   logic [39:0]   s_o;
   logic [63:0]   q_o;
   logic [W-1:0]  mx_o;
   logic [W-1:0]  mn_o;
   logic          sv;
   logic [15:0]   c_s;
   logic [39:0]   s_s;
   logic [63:0]   q_s;
   logic [W-1:0]  mx_s;
   logic [W-1:0]  mn_s;
   logic [W-1:0]  v;
   logic [W-1:0]  span;
   logic [W-1:0]  res_new;
   logic [32:0]   drm;
   logic [33:0]   srm;
   logic [33:0]   trial;
   logic [9:0]    wlen;
   logic [31:0]   rd;
   logic          hit;
   logic          acc_ph;
   logic [1:0]    jin;
   logic [2:0]    ri;
   logic          sel_wr;

   function automatic cws_regs_t op_start(cws_regs_t s, logic [DN-1:0] a,
                                          logic [31:0] b, logic sq, cws_state_t ret);
      cws_regs_t t;
      t = s;
      t.dnum = a;
      t.dden = b;
      t.dq = '0;
      t.drem = '0;
      t.ret = ret;
      t.st = sq ? ST_SQRT : ST_DIV;
      t.cnt = sq ? 7'(SQ_BITS / 2 - 1) : 7'(DN - 1);
      return t;
   endfunction

   assign prdata    = r.prdata;
   assign pready    = r.pready;
   assign pslverr   = r.pslverr;
   assign complete  = r.done;
   assign res_over  = r.over;
   assign res_go    = r.go;
   assign res_under = r.under;
   assign taking_in = r.taking;

   always_comb begin
      n = r;
      smp_we = 1'b0;
      acc_we = 1'b0;
      clr_code = 1'b0;
      sel_wr = 1'b0;
      acc_jdg = 2'b00;
      acc_w = r.result;
      rd = 32'h0000_0000;
      hit = 1'b1;
      v = smp_mem[r.idx];
      span = r.mx - r.mn;
      res_new = r.result;
      drm = {r.drem[31:0], r.dnum[DN-1]};
      srm = {r.drem[31:0], r.dnum[DN-1:DN-2]};
      trial = {r.dq[31:0], 2'b01};
      wlen = r.n >> r.ctl_win;
      jin = judge_over ? 2'd1 : (judge_under ? 2'd3 : (judge_go ? 2'd2 : 2'd0));
      ri = r.rec_wp - 3'd1 - r.rec_sel;
      sv = r.code_vld[r.stat_sel];
      c_s = sv ? cnt_mem[r.stat_sel] : 16'h0000;
      s_s = sv ? sum_mem[r.stat_sel] : 40'h00_0000_0000;
      q_s = sv ? sq_mem[r.stat_sel] : 64'h0;
      mx_s = sv ? max_mem[r.stat_sel] : '0;
      mn_s = sv ? min_mem[r.stat_sel] : '0;
      acc_ph = psel & penable & r.pready;

      //------------------------------------------------------------
      // APB slave
      //------------------------------------------------------------
      n.pready = psel & penable & ~r.pready;
      n.pslverr = 1'b0;
      if (paddr == `CWS_OFF_CTRL) begin
         rd[`CWS_CTL_TRIM] = r.ctl_trim;
         rd[`CWS_CTL_WIN +: 2] = r.ctl_win;
         rd[`CWS_CTL_AUTO] = r.ctl_auto;
         rd[`CWS_CTL_JSRC +: 2] = r.ctl_jsrc;
         rd[`CWS_CTL_CAP +: 2] = r.ctl_cap;
      end else if (paddr == `CWS_OFF_IDLE) rd = {22'h0, r.idle_cnt};
      else if (paddr == `CWS_OFF_ACQ) rd = {22'h0, r.acq_cnt};
      else if (paddr == `CWS_OFF_NZ) rd = {8'h00, r.nz_thr};
      else if (paddr == `CWS_OFF_DTIME) rd = {25'h0, r.done_time};
      else if (paddr == `CWS_OFF_RATIO) rd = {18'h0, r.ratio};
      else if (paddr == `CWS_OFF_CODE) rd = {25'h0, r.code};
      else if (paddr == `CWS_OFF_TARE) rd = {8'h00, r.tare};
      else if (paddr == `CWS_OFF_TARGET) rd = {8'h00, r.target};
      else if (paddr == `CWS_OFF_STATUS) begin
         rd[`CWS_STS_BUSY] = (r.st != ST_IDLE);
         rd[`CWS_STS_SBUSY] = r.st_pend | (r.st >= ST_SMEAN && r.ret >= ST_SMEAN);
         rd[`CWS_STS_PVLD] = r.pval;
         rd[`CWS_STS_SVLD] = r.sval;
         rd[`CWS_STS_DONE] = r.done;
         rd[`CWS_STS_TAKE] = r.taking;
      end else if (paddr == `CWS_OFF_RESULT) rd = {8'h00, r.result};
      else if (paddr == `CWS_OFF_SSEL) rd = {25'h0, r.stat_sel};
      else if (paddr == `CWS_OFF_SCOUNT) rd = {16'h0000, c_s};
      else if (paddr == `CWS_OFF_SSUM_LO) rd = s_s[31:0];
      else if (paddr == `CWS_OFF_SSUM_HI) rd = {24'h00_0000, s_s[39:32]};
      else if (paddr == `CWS_OFF_SMEAN) rd = r.st_mean;
      else if (paddr == `CWS_OFF_SMAX) rd = {8'h00, mx_s};
      else if (paddr == `CWS_OFF_SMIN) rd = {8'h00, mn_s};
      else if (paddr == `CWS_OFF_SRANGE) rd = {8'h00, mx_s - mn_s};
      else if (paddr == `CWS_OFF_SLAST) rd = {8'h00, sv ? last_mem[r.stat_sel] : 24'h0};
      else if (paddr == `CWS_OFF_SPDEV) rd = r.st_p;
      else if (paddr == `CWS_OFF_SSDEV) rd = r.st_s;
      else if (paddr == `CWS_OFF_RSEL) rd = {29'h0, r.rec_sel};
      else if (paddr == `CWS_OFF_RDATA) rd = {8'h00, rec_mem[ri][W-1:0]};
      else if (paddr == `CWS_OFF_RINFO) begin
         rd[6:0] = rec_mem[ri][30:24];
         rd[`CWS_RINFO_JDG +: 2] = rec_mem[ri][32:31];
         rd[`CWS_RINFO_VLD] = r.rec_vld[ri];
      end else hit = 1'b0;
      if (psel & penable & ~r.pready) begin
         n.prdata = pwrite ? 32'h0000_0000 : rd;
         n.pslverr = ~hit;
      end
      if (acc_ph & pwrite) begin
         if (paddr == `CWS_OFF_CTRL) begin
            n.ctl_trim = pwdata[`CWS_CTL_TRIM];
            n.ctl_win = pwdata[`CWS_CTL_WIN +: 2];
            n.ctl_auto = pwdata[`CWS_CTL_AUTO];
            n.ctl_jsrc = pwdata[`CWS_CTL_JSRC +: 2];
            n.ctl_cap = pwdata[`CWS_CTL_CAP +: 2];
            if (pwdata[`CWS_CTL_RCLR]) n.rec_vld = 8'h00;
            clr_code = pwdata[`CWS_CTL_CCLR];
         end else if (paddr == `CWS_OFF_IDLE) n.idle_cnt = pwdata[9:0];
         else if (paddr == `CWS_OFF_ACQ) n.acq_cnt = pwdata[9:0];
         else if (paddr == `CWS_OFF_NZ) n.nz_thr = pwdata[W-1:0];
         else if (paddr == `CWS_OFF_DTIME) n.done_time = pwdata[6:0];
         else if (paddr == `CWS_OFF_RATIO) n.ratio = pwdata[13:0];
         else if (paddr == `CWS_OFF_CODE) begin
            if (pwdata[6:0] < 7'(NCODES)) n.code = pwdata[6:0];
         end else if (paddr == `CWS_OFF_TARE) n.tare = pwdata[W-1:0];
         else if (paddr == `CWS_OFF_TARGET) n.target = pwdata[W-1:0];
         else if (paddr == `CWS_OFF_SSEL) begin
            if (pwdata[6:0] < 7'(NCODES)) begin
               n.stat_sel = pwdata[6:0];
               n.st_pend = 1'b1;
               sel_wr = 1'b1;
            end
         end else if (paddr == `CWS_OFF_RSEL) n.rec_sel = pwdata[2:0];
      end

      //------------------------------------------------------------
      // Quick target capture
      //------------------------------------------------------------
      if (capture_req) begin
         if (r.ctl_cap == 2'd1) n.target = sample_weight;
         else if (r.ctl_cap == 2'd2) n.target = r.result;
      end

      //------------------------------------------------------------
      // Done timer and judgement outputs
      //------------------------------------------------------------
      if (r.done) begin
         if (r.done_cnt == 32'h0) begin
            n.done = 1'b0;
            n.over = 1'b0;
            n.go = 1'b0;
            n.under = 1'b0;
         end else n.done_cnt = r.done_cnt - 32'h1;
      end

      //------------------------------------------------------------
      // Sequence and statistics engine
      //------------------------------------------------------------
      case (r.st)
         ST_IDLE: begin
            if (meas_start) begin
               n.n = '0;
               n.tick = '0;
               n.st = (r.idle_cnt == 10'h0) ? ST_ACQ : ST_WAIT;
            end else if (r.st_pend) begin
               n.st_pend = sel_wr;
               if (c_s == 16'h0) begin
                  n.st_mean = '0;
                  n.st_p = '0;
                  n.st_s = '0;
                  n.pval = 1'b0;
                  n.sval = 1'b0;
               end else n = op_start(n, DN'(s_s), {16'h0, c_s}, 1'b0, ST_SMEAN);
            end
         end
         ST_WAIT: if (sample_valid) begin
            n.tick = r.tick + 10'h1;
            if (r.tick + 10'h1 >= r.idle_cnt) n.st = ST_ACQ;
         end
         ST_ACQ: if (sample_valid) begin
            if (sample_weight <= r.nz_thr) n.st = ST_WIN;
            else begin
               smp_we = 1'b1;
               n.n = r.n + 10'h1;
               if (r.n + 10'h1 >= ((r.acq_cnt == 10'h0) ? 10'h1 : r.acq_cnt))
                  n.st = ST_WIN;
            end
         end
         ST_WIN: begin
            if (wlen == 10'h0) wlen = 10'h1;
            n.len = wlen;
            n.first = (r.n - wlen) >> 1;
            n.idx = (r.n - wlen) >> 1;
            n.last = ((r.n - wlen) >> 1) + wlen - 10'h1;
            n.mn = '1;
            n.mx = '0;
            n.all_sum = '0;
            n.sel_sum = '0;
            n.sel_n = '0;
            if (r.n == 10'h0) begin
               n.dq = '0;
               n.st = ST_FIN;
            end else n.st = ST_MM;
         end
         ST_MM: begin
            n.all_sum = r.all_sum + 34'(v);
            if (v < r.mn) n.mn = v;
            if (v > r.mx) n.mx = v;
            n.idx = r.idx + 10'h1;
            if (r.idx == r.last) begin
               n.idx = r.first;
               n.st = r.ctl_trim ? ST_BND : ST_AVG;
            end
         end
         ST_BND: begin
            n.emin = r.mn + (span >> 3);
            n.emax = r.mn + W'((27'(span) * 27'd7) >> 3);
            n.st = ST_SCAN;
         end
         ST_SCAN: begin
            if (v >= r.emin && v <= r.emax) begin
               n.sel_sum = r.sel_sum + 34'(v);
               n.sel_n = r.sel_n + 10'h1;
            end
            n.idx = r.idx + 10'h1;
            if (r.idx == r.last) n.st = ST_AVG;
         end
         ST_AVG: begin
            if (r.ctl_trim && r.sel_n != 10'h0)
               n = op_start(n, DN'(r.sel_sum), {22'h0, r.sel_n}, 1'b0, ST_SCALE);
            else
               n = op_start(n, DN'(r.all_sum), {22'h0, r.len}, 1'b0, ST_SCALE);
         end
         ST_SCALE: n = op_start(n, DN'(r.dq[31:0] * 46'(r.ratio)), `CWS_RATIO_UNIT,
                                1'b0, ST_FIN);
         ST_FIN: begin
            res_new = (|r.dq[DN-1:W]) ? '1 : r.dq[W-1:0];
            n.result = res_new;
            if (r.done_time != 7'h0) begin
               n.done = 1'b1;
               n.done_cnt = 32'(r.done_time * DONE_UNIT_CYC) - 32'h1;
               n.over = judge_over;
               n.go = judge_go;
               n.under = judge_under;
            end
            if (r.ctl_auto && r.ctl_jsrc != 2'd0 && res_new <= `CWS_WMAX) begin
               acc_we = 1'b1;
               acc_w = res_new;
               acc_jdg = jin;
            end
            n.st = ST_IDLE;
         end
         ST_SMEAN: begin
            n.st_mean = r.dq[31:0];
            n = op_start(n, DN'(s_s) * DN'(s_s), {16'h0, c_s}, 1'b0, ST_SQ);
         end
         ST_SQ: begin
            n.st_num = q_s - r.dq[63:0];
            n = op_start(n, DN'(q_s - r.dq[63:0]), {16'h0, c_s}, 1'b0, ST_SP);
         end
         ST_SP: n = op_start(n, {r.dq[63:0], 16'h0000}, 32'h0, 1'b1, ST_SPD);
         ST_SPD: begin
            n.st_p = r.dq[31:0];
            n.pval = 1'b1;
            if (c_s >= 16'h2)
               n = op_start(n, DN'(r.st_num), {16'h0, c_s - 16'h1}, 1'b0, ST_SS);
            else begin
               n.st_s = '0;
               n.sval = 1'b0;
               n.st = ST_IDLE;
            end
         end
         ST_SS: n = op_start(n, {r.dq[63:0], 16'h0000}, 32'h0, 1'b1, ST_SSD);
         ST_SSD: begin
            n.st_s = r.dq[31:0];
            n.sval = 1'b1;
            n.st = ST_IDLE;
         end
         ST_DIV: begin
            n.dnum = {r.dnum[DN-2:0], 1'b0};
            if (drm >= {1'b0, r.dden}) begin
               n.drem = 34'(drm - {1'b0, r.dden});
               n.dq = {r.dq[DN-2:0], 1'b1};
            end else begin
               n.drem = 34'(drm);
               n.dq = {r.dq[DN-2:0], 1'b0};
            end
            n.cnt = r.cnt - 7'h1;
            if (r.cnt == 7'h0) n.st = r.ret;
         end
         ST_SQRT: begin
            n.dnum = {r.dnum[DN-3:0], 2'b00};
            if (srm >= trial) begin
               n.drem = srm - trial;
               n.dq = {r.dq[DN-2:0], 1'b1};
            end else begin
               n.drem = srm;
               n.dq = {r.dq[DN-2:0], 1'b0};
            end
            n.cnt = r.cnt - 7'h1;
            if (r.cnt == 7'h0) n.st = r.ret;
         end
         default: n.st = ST_IDLE;
      endcase

      //------------------------------------------------------------
      // Accumulation into per-code totals
      //------------------------------------------------------------
      if (manual_accum && !acc_we) begin
         acc_we = 1'b1;
         acc_jdg = 2'd0;
      end
      if (r.ctl_jsrc == 2'd2) acc_w = acc_w - r.tare;
      av = r.code_vld[r.code] & ~clr_code;
      c_o = av ? cnt_mem[r.code] : 16'h0000;
      s_o = av ? sum_mem[r.code] : 40'h00_0000_0000;
      q_o = av ? sq_mem[r.code] : 64'h0;
      mx_o = (av && max_mem[r.code] > acc_w) ? max_mem[r.code] : acc_w;
      mn_o = (av && min_mem[r.code] < acc_w) ? min_mem[r.code] : acc_w;
      if (clr_code) n.code_vld[r.code] = 1'b0;
      if (acc_we) begin
         n.code_vld[r.code] = 1'b1;
         n.rec_vld[r.rec_wp] = 1'b1;
         n.rec_wp = r.rec_wp + 3'd1;
      end
      n.taking = (n.st == ST_ACQ);
   end

   always_ff @(posedge pclk) begin
      if (smp_we) smp_mem[r.n] <= sample_weight;
      if (acc_we) begin
         cnt_mem[r.code] <= c_o + 16'h1;
         sum_mem[r.code] <= s_o + 40'(acc_w);
         sq_mem[r.code] <= q_o + 64'(acc_w) * 64'(acc_w);
         max_mem[r.code] <= mx_o;
         min_mem[r.code] <= mn_o;
         last_mem[r.code] <= acc_w;
         rec_mem[r.rec_wp] <= {1'b1, acc_jdg, r.code, acc_w};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.ratio <= `CWS_RATIO_RST;
         r.acq_cnt <= `CWS_ACQ_RST;
      end else r <= n;
   end
endmodule

// File: cws_assertions.sv
// Port checker for the checkweigh sequence block
`timescale 1ns/1ps
module cws_checker #(parameter int DONE_UNIT_CYC = 10) (
   // Clock, reset and APB
   input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [31:0] prdata,
   // Sequence
   input wire logic sample_valid, meas_start, complete, res_over, res_go, res_under, taking_in
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   int hi;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) hi <= 0;
      else hi <= complete ? hi + 1 : 0;
   property p_rdy; $rose(penable) && psel |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready too long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_wrd; pready && pwrite |-> prdata == 0; endproperty
   a_wrd: assert property (p_wrd) else $error("data on write");
   property p_jdg;
      res_over || res_go || res_under |-> complete && $onehot({res_over, res_go, res_under});
   endproperty
   a_jdg: assert property (p_jdg) else $error("judge outside done");
   property p_jend; $fell(complete) |-> !(res_over || res_go || res_under); endproperty
   a_jend: assert property (p_jend) else $error("judge after done");
   property p_tkbeg; $rose(taking_in) |-> $past(meas_start || sample_valid); endproperty
   a_tkbeg: assert property (p_tkbeg) else $error("acquire off tick");
   property p_tkend; $fell(taking_in) |-> $past(sample_valid); endproperty
   a_tkend: assert property (p_tkend) else $error("acquire end off tick");
   property p_dur; $fell(complete) |-> hi != 0 && hi % DONE_UNIT_CYC == 0; endproperty
   a_dur: assert property (p_dur) else $error("done length");
   c_done: cover property ($rose(complete));
   c_take: cover property ($fell(taking_in));
   c_err: cover property (pslverr);
endmodule
bind cws_top cws_checker #(.DONE_UNIT_CYC(DONE_UNIT_CYC)) i_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .pready, .pslverr, .prdata, .sample_valid, .meas_start, .complete,
   .res_over, .res_go, .res_under, .taking_in);

// File: cws_load_cell.sv
// Load cell front end: one weight sample per tick
`timescale 1ns/1ps
module cws_load_cell #(parameter int TICK = 8) (
   // Clock and reset
   input wire logic pclk, presetn,
   // Live weight
   input wire logic [23:0] wt,
   output logic sample_valid,
   output logic [23:0] sample_weight
);
   int cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         sample_valid <= 0;
         sample_weight <= '0;
      end else begin
         cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
         sample_valid <= (cnt == TICK - 1);
         sample_weight <= wt;
      end
   end
endmodule

// File: testbench.sv
// Self-checking bench for the checkweigh sequence block
`timescale 1ns/1ps
module testbench import cws_pkg::*;;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic meas_start = 0, manual_accum = 0, capture_req = 0;
   logic judge_over = 0, judge_go = 1, judge_under = 0;
   logic pready, pslverr, sample_valid, complete, taking_in, res_over, res_go, res_under;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, res, res1, res2, lfsr = 32'heea0;
   logic [63:0] ts, tq, nm;
   logic [W-1:0] sample_weight, wt = 0;
   logic [W-1:0] q[$];
   int miscompares = 0, checked = 0, cutn = 99, cnt;
   cws_top #(.DONE_UNIT_CYC(10)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sample_valid, .sample_weight, .meas_start,
      .manual_accum, .capture_req, .judge_over, .judge_go, .judge_under, .complete,
      .res_over, .res_go, .res_under, .taking_in);
   cws_load_cell #(.TICK(8)) i_cell (.pclk, .presetn, .wt, .sample_valid, .sample_weight);
   initial forever #50 pclk = ~pclk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] isq(input logic [63:0] x);
      logic [63:0] t;
      logic [31:0] v;
      v = 0;
      for (int b = 31; b >= 0; b--) begin
         t = {32'h0, v | (32'h1 << b)};
         if (t * t <= x) v = t[31:0];
      end
      return v;
   endfunction
   always @(posedge pclk) begin
      lfsr <= lfsr_next(lfsr);
      wt <= (q.size() >= cutn) ? '0 : {8'h00, lfsr[15:0]} + 24'h1;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   function automatic logic [31:0] expv(input logic [31:0] ctl, input logic [13:0] r);
      logic [33:0] s, t;
      logic [W-1:0] lo, hi, e0, e1;
      int n, l, b, m;
      n = q.size();
      l = (n >> ctl[2:1]) > 0 ? n >> ctl[2:1] : 1;
      b = (n - l) / 2;
      s = 0;
      t = 0;
      m = 0;
      lo = '1;
      hi = 0;
      for (int i = b; i < b + l; i++) begin
         s += q[i];
         lo = q[i] < lo ? q[i] : lo;
         hi = q[i] > hi ? q[i] : hi;
      end
      e0 = W'(lo + (hi - lo) / 8);
      e1 = W'(lo + (hi - lo) * 7 / 8);
      for (int i = b; i < b + l; i++)
         if (q[i] >= e0 && q[i] <= e1) begin
            t += q[i];
            m++;
         end
      s = (ctl[0] && m > 0) ? t / m : s / l;
      s = s * r / 1000;
      return s > 34'hffffff ? 32'hffffff : s[31:0];
   endfunction
   task weigh(input logic [9:0] idl, acq, input logic [31:0] ctl, input logic [13:0] r,
              input int cut);
      int k, c;
      logic z;
      apb(1, 8'h04, idl);
      apb(1, 8'h08, acq);
      apb(1, 8'h14, r);
      apb(1, 8'h00, ctl);
      q = {};
      cutn = cut;
      k = 0;
      c = 0;
      z = 0;
      meas_start <= 1;
      @(posedge pclk);
      meas_start <= 0;
      while (q.size() < acq && !z) begin
         @(posedge pclk);
         if (sample_valid === 1'b1) begin
            if (k >= idl && sample_weight == 0) z = 1;
            else if (k >= idl) q.push_back(sample_weight);
            k++;
         end
      end
      while (complete !== 1'b1 && c < 2000) begin
         @(posedge pclk);
         c++;
      end
      chk({res_over, res_go, res_under}, 3'b010);
      c = 0;
      while (complete === 1'b1) begin
         @(posedge pclk);
         c++;
      end
      chk(c, 10);
      apb(0, 8'h28, 0);
      res = expv(ctl, r);
      chk(rd, res);
      $display("weighing done, %0d samples", q.size());
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 8'h14, 0);
      chk(rd, 32'h3e8);
      apb(0, 8'h2c, 0);
      chk(er, 1);
      apb(1, 8'h10, 1);
      weigh(2, 6, 32'h18, 1000, 99);
      res1 = res;
      apb(0, 8'h64, 0);
      chk(rd & 32'h8000_037f, 32'h8000_0200);
      weigh(0, 8, 32'h9a, 2000, 5);
      res2 = res;
      capture_req <= 1;
      @(posedge pclk);
      capture_req <= 0;
      manual_accum <= 1;
      @(posedge pclk);
      manual_accum <= 0;
      @(posedge pclk);
      apb(0, 8'h20, 0);
      chk(rd, res2);
      apb(0, 8'h64, 0);
      chk(rd & 32'h8000_037f, 32'h8000_0000);
      apb(0, 8'h60, 0);
      chk(rd, res2);
      apb(1, 8'h30, 0);
      do apb(0, 8'h24, 0); while (rd[1] !== 1'b0);
      chk(rd[3:2], 2'b11);
      cnt = (res2 <= 32'd99999) ? 3 : 2;
      apb(0, 8'h34, 0);
      chk(rd, cnt);
      apb(0, 8'h40, 0);
      chk(rd, (res1 + (cnt - 1) * res2) / cnt);
      apb(0, 8'h44, 0);
      chk(rd, res1 > res2 ? res1 : res2);
      ts = 64'(res1) + 64'(cnt - 1) * 64'(res2);
      tq = 64'(res1) * 64'(res1) + 64'(cnt - 1) * 64'(res2) * 64'(res2);
      nm = tq - ts * ts / 64'(cnt);
      apb(0, 8'h54, 0);
      chk(rd, isq(nm / 64'(cnt)));
      apb(0, 8'h58, 0);
      chk(rd, isq(nm / 64'(cnt - 1)));
      apb(1, 8'h00, 32'h100);
      apb(0, 8'h64, 0);
      chk(rd[31], 0);
      apb(0, 8'h34, 0);
      chk(rd, cnt);
      $display("statistics test done");
      weigh(1, 12, 32'h1, 1000, 99);
      apb(1, 8'h00, 32'h40);
      capture_req <= 1;
      @(posedge pclk);
      res = {8'h00, sample_weight};
      capture_req <= 0;
      apb(0, 8'h20, 0);
      chk(rd, res);
      $display("capture test done");
      finish_test;
   end
   initial begin
      #3000000;
      miscompares++;
      finish_test;
   end
endmodule
